// ==== logic/nmr_pkg.sv ====
package nmr_pkg;

   // ****************************************
   // command decode
   // ****************************************
   localparam int unsigned CMD_W       = 16;
   localparam int unsigned OPC_W       = 7;
   localparam int unsigned OPC_LSB     = 9;
   localparam logic [6:0]  OPC_WHOLE   = 7'h00;
   localparam logic [6:0]  OPC_RECEIVE = 7'h14;
   localparam logic [6:0]  OPC_XMIT    = 7'h2C;

   // ****************************************
   // spare-mask fields
   // ****************************************
   localparam int unsigned WHOLE_W          = 9;
   localparam int unsigned PATH_W           = 5;
   localparam int unsigned B_TRANSCEIVER    = 0;
   localparam int unsigned B_LINE_CODEC     = 1;
   localparam int unsigned B_NETWORK        = 2;
   localparam int unsigned B_FIFO_CONTROL   = 3;
   localparam int unsigned B_AUTOINIT       = 4;
   localparam int unsigned B_BUS_INTERFACE  = 5;
   localparam int unsigned B_SIDEBAND       = 6;
   localparam int unsigned B_OSCILLATOR     = 7;
   localparam int unsigned B_DMA_ENGINES    = 8;
   localparam int unsigned P_DMA_INDEX      = 4;
   localparam int unsigned P_LOW_MSB        = 3;

   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [WHOLE_W-1:0] WHOLE_RST = 9'h000;
   localparam logic [PATH_W-1:0]  PATH_RST  = 5'h00;
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned EEPROM_MAX_NS    = 1000000;
   localparam int unsigned EEPROM_MAX_CYC   = EEPROM_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned PATH_SETTLE_NS   = 320;
   localparam int unsigned PATH_SETTLE_CYC  =
      (PATH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W            = 15;

   typedef enum logic [3:0] {
      NMR_IDLE   = 4'h1,
      NMR_FIRE   = 4'h2,
      NMR_EEWAIT = 4'h4,
      NMR_SETTLE = 4'h8
   } nmr_state_t;

   typedef enum logic [1:0] {
      NMR_K_WHOLE   = 2'h0,
      NMR_K_RECEIVE = 2'h1,
      NMR_K_XMIT    = 2'h2
   } nmr_kind_t;

endpackage : nmr_pkg

// ==== logic/nmr_settle_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module nmr_settle_timer (
   input  wire logic                       clk_sys,   // core clock
   input  wire logic                       srst,      // sync reset
   input  wire logic                       load,      // start a wait
   input  wire logic [nmr_pkg::TMR_W-1:0]  loadValue, // cycles to wait
   output var  logic                       expired    // one-cycle end pulse
);
   import nmr_pkg::*;

   logic [TMR_W-1:0] count;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count <= '0;
      end else if (load) begin
         count <= loadValue;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   // a reload aborts a pending expiry
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         expired <= 1'b0;
      end else begin
         expired <= (count == {{(TMR_W-1){1'b0}}, 1'b1}) && !load;
      end
   end

endmodule : nmr_settle_timer
`default_nettype wire

// ==== logic/nmr_pulse_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
module nmr_pulse_bank #(
   parameter int unsigned W = 5
) (
   input  wire logic         clk_sys,   // core clock
   input  wire logic         srst,      // sync reset
   input  wire logic         fire,      // issue resets this cycle
   input  wire logic [W-1:0] spareMask, // set bit keeps reset away
   output var  logic [W-1:0] pulse      // one-cycle sub-unit resets
);
   import nmr_pkg::*;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_unit
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               pulse[i] <= 1'b0;
            end else begin
               pulse[i] <= fire && !spareMask[i];
            end
         end
      end
   endgenerate

endmodule : nmr_pulse_bank
`default_nettype wire

// ==== logic/nmr_reset_sequencer.sv ====
// Contract
// - whole-card reset holds busy flag until done
// - whole-card mask bits spare their sub-units
// - bit 2 spares network core, statistics, PHY
// - bit 4 clear: reset autoinit, reload EEPROM
// - bit 5 clear: reset bus interface, interrupt registers
// - bit 8 clear: reset both DMA engines
// - config space untouched except aliased registers
// - whole-card reset may last 1 ms
// - receive reset opcode 0010100, mask bits 0-3, 8
// - path resets hold busy flag until done
// - receive bits 0,1 spare transceiver, codec
// - receive bit 2 clear: network, disable, filter
// - receive bit 3 clear: flush FIFO, threshold
// - receive bit 8 clear: reset upload logic
// - transmit reset opcode 0101100, mask bits 0-3, 8
// - transmit bits 0,1 spare transceiver, codec
// - transmit bit 2 clear: network, disable, status
// - transmit bit 3 clear: flush FIFO, thresholds
// - transmit bit 8 clear: reset download logic
`timescale 1ns/1ns
`default_nettype none
module nmr_reset_sequencer #(
   parameter int unsigned EepromWaitCycles = nmr_pkg::EEPROM_MAX_CYC
) (
   input  wire logic                         clk_sys,          // core clock
   input  wire logic                         srst,             // sync reset
   input  wire logic                         cmdValid,         // command strobe
   input  wire logic [nmr_pkg::CMD_W-1:0]    cmdWord,          // command word
   input  wire logic                         eepromLoadDone,   // reload finished
   output var  logic                         commandBusyFlag,  // command busy
   output var  logic [nmr_pkg::WHOLE_W-1:0]  wholeResetPulse,  // whole-card resets
   output var  logic                         aliasedCfgReload, // aliased cfg reset
   output var  logic                         eepromTimeout,    // reload timed out
   output var  logic [nmr_pkg::PATH_W-1:0]   rxResetPulse,     // receive resets
   output var  logic [nmr_pkg::PATH_W-1:0]   txResetPulse      // transmit resets
);
   import nmr_pkg::*;

   // ****************************************
   // decode
   // ****************************************
   function automatic logic cmdIs(input logic [CMD_W-1:0] w, input logic [OPC_W-1:0] opc);
      cmdIs = (w[CMD_W-1:OPC_LSB] == opc);
   endfunction : cmdIs

   function automatic logic [PATH_W-1:0] pathMask(input logic [WHOLE_W-1:0] p);
      pathMask = {p[B_DMA_ENGINES], p[P_LOW_MSB:0]};
   endfunction : pathMask

   nmr_state_t         state;
   nmr_state_t         next_state;
   nmr_kind_t          kind;
   logic [WHOLE_W-1:0] param;
   logic               isWhole;
   logic               isRx;
   logic               isTx;
   logic               accept;
   logic               timerLoad;
   logic [TMR_W-1:0]   timerValue;
   logic               timerExpired;
   logic               needReload;

   assign isWhole    = cmdIs(cmdWord, OPC_WHOLE);
   assign isRx       = cmdIs(cmdWord, OPC_RECEIVE);
   assign isTx       = cmdIs(cmdWord, OPC_XMIT);
   // host must poll busy; commands during a reset are dropped
   assign accept     = cmdValid && (state == NMR_IDLE) && (isWhole || isRx || isTx);
   assign needReload = (kind == NMR_K_WHOLE) && !param[B_AUTOINIT];
   assign timerLoad  = (state == NMR_FIRE);
   assign timerValue = needReload ? TMR_W'(EepromWaitCycles) : TMR_W'(PATH_SETTLE_CYC);

   // ****************************************
   // command capture
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         kind  <= NMR_K_WHOLE;
         param <= WHOLE_RST;
      end else if (accept) begin
         kind  <= isWhole ? NMR_K_WHOLE : (isRx ? NMR_K_RECEIVE : NMR_K_XMIT);
         param <= cmdWord[WHOLE_W-1:0];
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   always_comb begin
      next_state = state;
      case (state)
         NMR_IDLE: begin
            if (accept) begin
               next_state = NMR_FIRE;
            end
         end
         NMR_FIRE: begin
            next_state = needReload ? NMR_EEWAIT : NMR_SETTLE;
         end
         NMR_EEWAIT: begin
            // reload can take up to the full wait, never longer
            if (eepromLoadDone || timerExpired) begin
               next_state = NMR_IDLE;
            end
         end
         NMR_SETTLE: begin
            if (timerExpired) begin
               next_state = NMR_IDLE;
            end
         end
         default: begin
            next_state = NMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= NMR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         commandBusyFlag <= 1'b0;
      end else begin
         commandBusyFlag <= (next_state != NMR_IDLE);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         eepromTimeout <= 1'b0;
      end else begin
         eepromTimeout <= (state == NMR_EEWAIT) && timerExpired && !eepromLoadDone;
      end
   end

   // only the aliased registers follow a whole-card reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aliasedCfgReload <= 1'b0;
      end else begin
         aliasedCfgReload <= (state == NMR_FIRE) && (kind == NMR_K_WHOLE);
      end
   end

   nmr_settle_timer u_timer (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .load      (timerLoad),
      .loadValue (timerValue),
      .expired   (timerExpired)
   );

   // ****************************************
   // sub-unit reset pulses
   // ****************************************
   // bit 5 also clears interrupt regs, bit 8 pointers and dma control
   nmr_pulse_bank #(.W(WHOLE_W)) u_whole (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .fire      ((state == NMR_FIRE) && (kind == NMR_K_WHOLE)),
      .spareMask (param),
      .pulse     (wholeResetPulse)
   );

   // bit 2 disables the path, bit 3 flushes and defaults thresholds
   nmr_pulse_bank #(.W(PATH_W)) u_rx (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .fire      ((state == NMR_FIRE) && (kind == NMR_K_RECEIVE)),
      .spareMask (pathMask(param)),
      .pulse     (rxResetPulse)
   );

   nmr_pulse_bank #(.W(PATH_W)) u_tx (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .fire      ((state == NMR_FIRE) && (kind == NMR_K_XMIT)),
      .spareMask (pathMask(param)),
      .pulse     (txResetPulse)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   logic [TMR_W:0] busyRun;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busyRun <= '0;
      end else if (commandBusyFlag) begin
         busyRun <= busyRun + 1'b1;
      end else begin
         busyRun <= '0;
      end
   end

   sequence s_accWhole;
      accept && isWhole;
   endsequence

   sequence s_accPath;
      accept && (isRx || isTx);
   endsequence

   sequence s_pathBusy;
      commandBusyFlag [*8] ##[1:4] !commandBusyFlag;
   endsequence

   busy_rises_a: assert property (accept |=> commandBusyFlag)
      else $error("busy flag not set after command");

   busy_drop_a: assert property (busyRun <= (TMR_W+1)'(EepromWaitCycles + 4))
      else $error("whole reset busy beyond wait limit");

   path_busy_a: assert property (s_accPath |=> s_pathBusy)
      else $error("path reset busy window wrong");

   whole_mask_a: assert property (s_accWhole |=> ##1
         (wholeResetPulse == ~$past(cmdWord[WHOLE_W-1:0], 2)))
      else $error("whole reset pulses ignore spare mask");

   net_spare_a: assert property (s_accWhole ##0 cmdWord[B_NETWORK]
         |=> ##1 !wholeResetPulse[B_NETWORK])
      else $error("network reset despite spare bit");

   reload_wait_a: assert property (s_accWhole ##0 !cmdWord[B_AUTOINIT]
         |=> ##1 wholeResetPulse[B_AUTOINIT] && state == NMR_EEWAIT)
      else $error("autoinit reset or reload missing");

   bus_clear_a: assert property (s_accWhole ##0 !cmdWord[B_BUS_INTERFACE]
         |=> ##1 wholeResetPulse[B_BUS_INTERFACE] ##1 !wholeResetPulse[B_BUS_INTERFACE])
      else $error("bus interface reset not one pulse");

   dma_reset_a: assert property (s_accWhole ##0 !cmdWord[B_DMA_ENGINES]
         |=> ##1 wholeResetPulse[B_DMA_ENGINES])
      else $error("dma engines not reset");

   cfg_alias_a: assert property (aliasedCfgReload |-> wholeResetPulse == ~param)
      else $error("aliased cfg reload outside whole reset");

   rx_mask_a: assert property (accept && isRx |=> ##1
         rxResetPulse == ~pathMask($past(cmdWord[WHOLE_W-1:0], 2)) && txResetPulse == '0)
      else $error("receive reset pulses wrong");

   tx_mask_a: assert property (accept && isTx |=> ##1
         txResetPulse == ~pathMask($past(cmdWord[WHOLE_W-1:0], 2)) && rxResetPulse == '0)
      else $error("transmit reset pulses wrong");

   busy_ignore_a: assert property (commandBusyFlag && cmdValid |=> $stable(param))
      else $error("command taken while busy");

   // ****************************************
   // path field checks
   // ****************************************
   sequence s_accRx;
      accept && isRx;
   endsequence

   sequence s_accTx;
      accept && isTx;
   endsequence

   rx_net_a: assert property (s_accRx ##0 !cmdWord[B_NETWORK]
         |=> ##1 rxResetPulse[B_NETWORK])
      else $error("receive network reset missing");

   upload_reset_a: assert property (s_accRx ##0 !cmdWord[B_DMA_ENGINES]
         |=> ##1 rxResetPulse[P_DMA_INDEX])
      else $error("upload logic not reset");

   tx_fifo_a: assert property (s_accTx ##0 !cmdWord[B_FIFO_CONTROL]
         |=> ##1 txResetPulse[B_FIFO_CONTROL])
      else $error("transmit fifo not flushed");

   download_reset_a: assert property (s_accTx ##0 !cmdWord[B_DMA_ENGINES]
         |=> ##1 txResetPulse[P_DMA_INDEX])
      else $error("download logic not reset");

   // ****************************************
   // pulse shape and refusal checks
   // ****************************************
   pulse_single_a: assert property (wholeResetPulse != '0 |=> wholeResetPulse == '0)
      else $error("whole reset pulse longer than one cycle");

   path_quiet_a: assert property (!commandBusyFlag |-> rxResetPulse == '0 && txResetPulse == '0)
      else $error("path reset pulse outside a command");

   // a foreign opcode must not start anything
   bad_opc_a: assert property (cmdValid && !commandBusyFlag && !(isWhole || isRx || isTx)
         |=> !commandBusyFlag)
      else $error("unknown opcode started a reset");

   settle_end_a: assert property ((state == NMR_SETTLE) && timerExpired
         |=> !commandBusyFlag)
      else $error("busy held after settle time");

   tmo_pulse_a: assert property (eepromTimeout
         |-> !commandBusyFlag && ($past(state) == NMR_EEWAIT))
      else $error("timeout pulse outside reload wait");

endmodule : nmr_reset_sequencer
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import nmr_pkg::*;

   // ****************************************
   // clock, reset and design
   // ****************************************
   localparam int unsigned EeWait = 20;

   logic                 clk_sys;
   logic                 srst;
   logic                 cmdValid;
   logic [CMD_W-1:0]     cmdWord;
   logic                 eepromLoadDone;
   logic                 commandBusyFlag;
   logic [WHOLE_W-1:0]   wholeResetPulse;
   logic                 aliasedCfgReload;
   logic                 eepromTimeout;
   logic [PATH_W-1:0]    rxResetPulse;
   logic [PATH_W-1:0]    txResetPulse;
   int                   fails;
   int                   nCompared;

   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

   nmr_reset_sequencer #(.EepromWaitCycles(EeWait)) uut (
      .clk_sys          (clk_sys),
      .srst             (srst),
      .cmdValid         (cmdValid),
      .cmdWord          (cmdWord),
      .eepromLoadDone   (eepromLoadDone),
      .commandBusyFlag  (commandBusyFlag),
      .wholeResetPulse  (wholeResetPulse),
      .aliasedCfgReload (aliasedCfgReload),
      .eepromTimeout    (eepromTimeout),
      .rxResetPulse     (rxResetPulse),
      .txResetPulse     (txResetPulse)
   );

   // ****************************************
   // compares and closing
   // ****************************************
   task automatic chk_vec(input logic [20:0] got, input logic [20:0] exp);
      nCompared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic chk_cnt(input int got, input int exp);
      nCompared++;
      if (got != exp) begin
         fails++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic close_out();
      $display("mismatches %0d compared %0d", fails, nCompared);
      if (fails == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   function automatic logic [4:0] pexp(input logic [8:0] m);
      return ~{m[8], m[3:0]};
   endfunction : pexp

   // ****************************************
   // one command, judged cycle by cycle
   // ****************************************
   // entered and left at a falling edge; n counts rising edges after take
   task automatic run_cmd(input logic [6:0] opc, input logic [8:0] mask,
                          input logic [8:0] expW, input logic [4:0] expR,
                          input logic [4:0] expT, input logic expA,
                          input int doneAt, input int expEnd,
                          input int expTmo, input logic intrude);
      int n;
      int tmo;
      n = 0;
      tmo = 0;
      cmdValid = 1'b1;
      cmdWord = {opc, mask};
      do begin
         @(negedge clk_sys);
         n++;
         eepromLoadDone = (n == doneAt);
         // a second command while busy must leave no trace
         cmdValid = intrude && (n == 3);
         cmdWord = {OPC_XMIT, 9'h000};
         if (eepromTimeout === 1'b1)
            tmo++;
         chk_vec({commandBusyFlag, wholeResetPulse, aliasedCfgReload, rxResetPulse,
                  txResetPulse},
                 {n < expEnd, (n == 2) ? {expW, expA, expR, expT} : 20'h00000});
      end while (n < expEnd);
      eepromLoadDone = 1'b0;
      cmdValid = 1'b0;
      chk_cnt(tmo, expTmo);
   endtask : run_cmd

   // ****************************************
   // scenarios
   // ****************************************
   task automatic whole_masks();
      logic [8:0] m;
      for (int i = 0; i <= 9; i++) begin
         m = (i < 9) ? 9'h001 << i : 9'h000;
         // spared autoinit skips the reload wait; busy drops on the edge that sees done
         run_cmd(OPC_WHOLE, m, ~m, 5'h00, 5'h00, 1'b1, m[4] ? 0 : 4,
                 m[4] ? 11 : 5, 0, i == 0);
      end
   endtask : whole_masks

   task automatic whole_timeout();
      // timer ends the wait one edge after it runs out, busy falls with the timeout pulse
      run_cmd(OPC_WHOLE, 9'h000, 9'h1FF, 5'h00, 5'h00, 1'b1, 0, EeWait + 3, 1,
              1'b1);
   endtask : whole_timeout

   task automatic path_masks();
      logic [8:0] tbl [8];
      tbl = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h008, 9'h100, 9'h0F0, 9'h1FF};
      // each path reset stands for a recovery after a receive or transmit error
      foreach (tbl[k]) begin
         run_cmd(OPC_RECEIVE, tbl[k], 9'h000, pexp(tbl[k]), 5'h00, 1'b0, 0, 11, 0,
                 k == 1);
         run_cmd(OPC_XMIT, tbl[k], 9'h000, 5'h00, pexp(tbl[k]), 1'b0, 0, 11, 0,
                 k == 2);
      end
   endtask : path_masks

   task automatic refused_cmds();
      logic [6:0] bad [3];
      bad = '{7'h01, 7'h15, 7'h2D};
      foreach (bad[k]) begin
         cmdValid = 1'b1;
         cmdWord = {bad[k], 9'h000};
         @(negedge clk_sys);
         cmdValid = 1'b0;
         repeat (12) begin
            @(negedge clk_sys);
            chk_vec({commandBusyFlag, wholeResetPulse, aliasedCfgReload, rxResetPulse,
                     txResetPulse}, 21'h000000);
         end
      end
   endtask : refused_cmds

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      srst = 1'b1;
      cmdValid = 1'b0;
      cmdWord = 16'h0000;
      eepromLoadDone = 1'b0;
      fails = 0;
      nCompared = 0;
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      whole_masks();
      whole_timeout();
      path_masks();
      refused_cmds();
      close_out();
   end

   // expected run is about 315 cycles
   initial begin
      #(4000 * CLK_PERIOD_NS);
      fails++;
      close_out();
   end

endmodule : tb_top
`default_nettype wire
